// file: include/flash_dl_pkg.sv
// Constants, types and register map shared by the download result checker.
package flash_dl_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned RAM_AW = 8;
  localparam int unsigned IDX_W = 4;

  // Register byte offsets on the bus.
  localparam logic [11:0] OFF_CMD = 12'h000;
  localparam logic [11:0] OFF_PROG_SEL = 12'h004;
  localparam logic [11:0] OFF_KEY = 12'h008;
  localparam logic [11:0] OFF_DEST = 12'h00C;
  localparam logic [11:0] OFF_GPR0 = 12'h010;
  localparam logic [11:0] OFF_GPR1 = 12'h014;
  localparam logic [11:0] OFF_RESULT = 12'h018;
  // Window onto the on-chip RAM, one byte per aligned word.
  localparam int unsigned RAM_SEL_BIT = 10;
  localparam int unsigned RAM_IDX_LSB = 2;

  // Command codes written to the command register.
  localparam logic [7:0] CMD_DOWNLOAD = 8'h01;
  localparam logic [7:0] CMD_FREQ_CHECK = 8'h02;
  localparam logic [7:0] CMD_ERASE_CHECK = 8'h03;
  localparam logic [7:0] CMD_ADDR_CHECK = 8'h04;

  // Status bit positions.
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_DONE_BIT = 1;

  // Result byte field positions; bits 7 to 3 are always zero.
  localparam int unsigned RES_SEL_BIT = 2;
  localparam int unsigned RES_KEY_BIT = 1;
  localparam int unsigned RES_FAIL_BIT = 0;

  localparam logic [7:0] KEY_VALUE = 8'hA5;
  // Downloadable programs that are mapped; other select bits are unmapped.
  localparam logic [7:0] PROG_MAP = 8'h03;
  localparam logic [IDX_W-1:0] PROG_LAST = 4'hF;
  localparam logic [7:0] PROG_A_SEED = 8'h3C;
  localparam logic [7:0] PROG_B_SEED = 8'hC3;

  // Limits for the parameter checks, plain defaults.
  localparam logic [31:0] FREQ_MIN_KHZ = 32'h0000_1F40;
  localparam logic [31:0] FREQ_MAX_KHZ = 32'h0000_4E20;
  localparam logic [31:0] ERASE_BLOCKS = 32'h0000_0008;
  localparam logic [1:0] ADDR_ALIGN_MASK = 2'h3;

  // Result codes.
  localparam logic [7:0] RC_OK = 8'h00;
  localparam logic [7:0] RC_SUM = 8'h11;
  localparam logic [7:0] RC_SIZE = 8'h12;
  localparam logic [7:0] RC_DEVICE = 8'h21;
  localparam logic [7:0] RC_CLK_MODE = 8'h22;
  localparam logic [7:0] RC_BITRATE = 8'h24;
  localparam logic [7:0] RC_IN_FREQ = 8'h25;
  localparam logic [7:0] RC_DIV_RATIO = 8'h26;
  localparam logic [7:0] RC_OP_FREQ = 8'h27;
  localparam logic [7:0] RC_BLOCK = 8'h29;
  localparam logic [7:0] RC_ADDR = 8'h2A;
  localparam logic [7:0] RC_LENGTH = 8'h2B;
  localparam logic [7:0] RC_ERASE = 8'h51;
  localparam logic [7:0] RC_ERASE_INC = 8'h52;
  localparam logic [7:0] RC_PROG = 8'h53;
  localparam logic [7:0] RC_SELECT = 8'h54;
  localparam logic [7:0] RC_COMMAND = 8'h80;
  localparam logic [7:0] RC_BITRATE_CONF = 8'hFF;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_COPY = 5'h02,
    ST_VREAD = 5'h04,
    ST_VCHK = 5'h08,
    ST_RESULT = 5'h10
  } dl_state_t;
endpackage

// file: include/ram_port_if.sv
// Port bundle between the sequencer and its on-chip RAM.
`timescale 1ns/1ps
`default_nettype none
interface ram_port_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic we;
  logic [7:0] rdata;
  modport ctrl (output addr, output wdata, output we, input rdata);
  modport mem (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// file: hw/dl_ram.sv
// On-chip RAM of 256 bytes with registered read data.
`timescale 1ns/1ps
`default_nettype none
module dl_ram (
  input wire logic mclk_in,
  input wire logic rst_in,
  ram_port_if.mem port
);
  typedef struct packed {
    logic [255:0][7:0] mem;
    logic [7:0] rdata;
  } ram_state_t;

  ram_state_t st_r;
  ram_state_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rdata = st_r.mem[port.addr];
    if (port.we)
    begin
      st_nxt.mem[port.addr] = port.wdata;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign port.rdata = st_r.rdata;
endmodule // dl_ram
`default_nettype wire

// file: hw/flash_download_result_check.sv
// Flash download sequencer with result byte, parameter registers and AHB-Lite slave.
`timescale 1ns/1ps
`default_nettype none
module flash_download_result_check (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic [31:0] hrdata_out,
  output logic hresp_out
);
  typedef struct packed {
    flash_dl_pkg::dl_state_t fsm;
    logic [7:0] prog_sel;
    logic [7:0] key;
    logic [7:0] dest;
    logic [31:0] gpr0;
    logic [31:0] gpr1;
    logic [7:0] result_byte;
    logic [flash_dl_pkg::IDX_W-1:0] idx;
    logic sel_err;
    logic key_err;
    logic fail;
    logic done;
    logic ap_pend;
    logic ap_write;
    logic [flash_dl_pkg::ADDR_W-1:0] ap_addr;
    logic ram_rd_wait;
    logic hready;
    logic [31:0] hrdata;
    logic hresp;
  } ctl_state_t;

  ctl_state_t st_r;
  ctl_state_t st_nxt;
  ram_port_if ram ();

  dl_ram u_ram (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .port(ram.ctrl)
  );

  // Program image bytes; the table is generated, not stored.
  function automatic logic [7:0] prog_byte(input logic [7:0] sel,
                                           input logic [flash_dl_pkg::IDX_W-1:0] i);
    logic [7:0] seed;
    seed = sel[1] ? flash_dl_pkg::PROG_B_SEED : flash_dl_pkg::PROG_A_SEED;
    return seed ^ {i, i};
  endfunction

  // Selection must be exactly one mapped program.
  function automatic logic select_bad(input logic [7:0] sel);
    logic [3:0] cnt;
    cnt = '0;
    for (int b = 0; b < 8; b++)
    begin
      cnt = cnt + 4'(sel[b]);
    end
    return (cnt != 4'h1) || ((sel & ~flash_dl_pkg::PROG_MAP) != 8'h00);
  endfunction

  function automatic logic [7:0] ram_slot(input logic [7:0] base,
                                          input logic [flash_dl_pkg::IDX_W-1:0] i);
    return 8'(base + 8'(i) + 8'h01);
  endfunction

  function automatic logic [7:0] make_result(input logic s, input logic k, input logic f);
    logic [7:0] r;
    r = 8'h00;
    r[flash_dl_pkg::RES_SEL_BIT] = s;
    r[flash_dl_pkg::RES_KEY_BIT] = k;
    r[flash_dl_pkg::RES_FAIL_BIT] = f;
    return r;
  endfunction

  function automatic logic [7:0] result_code(input logic s, input logic k, input logic f);
    if (s || k)
    begin
      return flash_dl_pkg::RC_SELECT;
    end
    else if (f)
    begin
      return flash_dl_pkg::RC_SUM;
    end
    return flash_dl_pkg::RC_OK;
  endfunction

  logic busy;
  logic ap_is_ram;
  logic [7:0] ram_idx;
  logic [31:0] rd_word;
  logic start_sel_err;
  logic start_key_err;

  assign busy = (st_r.fsm != flash_dl_pkg::ST_IDLE);
  assign ap_is_ram = st_r.ap_addr[flash_dl_pkg::RAM_SEL_BIT];
  assign ram_idx = st_r.ap_addr[flash_dl_pkg::RAM_IDX_LSB +: flash_dl_pkg::RAM_AW];
  assign start_sel_err = select_bad(st_r.prog_sel);
  assign start_key_err = (st_r.key != flash_dl_pkg::KEY_VALUE);

  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (st_r.ap_addr)
      flash_dl_pkg::OFF_CMD:
      begin
        rd_word[flash_dl_pkg::ST_BUSY_BIT] = busy;
        rd_word[flash_dl_pkg::ST_DONE_BIT] = st_r.done;
      end
      flash_dl_pkg::OFF_PROG_SEL: rd_word[7:0] = st_r.prog_sel;
      flash_dl_pkg::OFF_KEY: rd_word[7:0] = st_r.key;
      flash_dl_pkg::OFF_DEST: rd_word[7:0] = st_r.dest;
      flash_dl_pkg::OFF_GPR0: rd_word = st_r.gpr0;
      flash_dl_pkg::OFF_GPR1: rd_word = st_r.gpr1;
      flash_dl_pkg::OFF_RESULT: rd_word[7:0] = st_r.result_byte;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.hresp = 1'b0;
    ram.addr = 8'h00;
    ram.wdata = 8'h00;
    ram.we = 1'b0;

    // Address phase capture; every transfer gets at least one wait state.
    if (hsel_in && htrans_in[1] && hready_in)
    begin
      st_nxt.ap_pend = 1'b1;
      st_nxt.ap_write = hwrite_in;
      st_nxt.ap_addr = haddr_in[flash_dl_pkg::ADDR_W-1:0];
      st_nxt.hready = 1'b0;
    end

    if (st_r.ram_rd_wait)
    begin
      st_nxt.hrdata = {24'h00_0000, ram.rdata};
      st_nxt.ram_rd_wait = 1'b0;
      st_nxt.ap_pend = 1'b0;
      st_nxt.hready = 1'b1;
    end
    else if (st_r.ap_pend && ap_is_ram)
    begin
      // RAM belongs to the sequencer while it runs, so the bus waits.
      if (!busy)
      begin
        ram.addr = ram_idx;
        if (st_r.ap_write)
        begin
          ram.we = 1'b1;
          ram.wdata = hwdata_in[7:0];
          st_nxt.ap_pend = 1'b0;
          st_nxt.hready = 1'b1;
        end
        else
        begin
          st_nxt.ram_rd_wait = 1'b1;
        end
      end
    end
    else if (st_r.ap_pend)
    begin
      st_nxt.ap_pend = 1'b0;
      st_nxt.hready = 1'b1;
      if (!st_r.ap_write)
      begin
        st_nxt.hrdata = rd_word;
      end
      else
      begin
        unique case (st_r.ap_addr)
          flash_dl_pkg::OFF_CMD:
          begin
            // Commands while busy are dropped; software polls the busy bit.
            if (!busy)
            begin
              st_nxt.done = 1'b0;
              unique case (hwdata_in[7:0])
                flash_dl_pkg::CMD_DOWNLOAD:
                begin
                  st_nxt.sel_err = start_sel_err;
                  st_nxt.key_err = start_key_err;
                  st_nxt.idx = '0;
                  if (start_sel_err || start_key_err)
                  begin
                    st_nxt.fail = 1'b1;
                    st_nxt.fsm = flash_dl_pkg::ST_RESULT;
                  end
                  else
                  begin
                    st_nxt.fail = 1'b0;
                    st_nxt.fsm = flash_dl_pkg::ST_COPY;
                  end
                end
                flash_dl_pkg::CMD_FREQ_CHECK:
                begin
                  // Frequency parameter in general register 0.
                  st_nxt.gpr0[7:0] = ((st_r.gpr0 < flash_dl_pkg::FREQ_MIN_KHZ) ||
                                      (st_r.gpr0 > flash_dl_pkg::FREQ_MAX_KHZ)) ?
                    flash_dl_pkg::RC_OP_FREQ : flash_dl_pkg::RC_OK;
                  st_nxt.done = 1'b1;
                end
                flash_dl_pkg::CMD_ERASE_CHECK:
                begin
                  st_nxt.gpr0[7:0] = (st_r.gpr0 >= flash_dl_pkg::ERASE_BLOCKS) ?
                    flash_dl_pkg::RC_BLOCK : flash_dl_pkg::RC_OK;
                  st_nxt.done = 1'b1;
                end
                flash_dl_pkg::CMD_ADDR_CHECK:
                begin
                  st_nxt.gpr0[7:0] = ((st_r.gpr1[1:0] & flash_dl_pkg::ADDR_ALIGN_MASK) != 2'h0) ?
                    flash_dl_pkg::RC_ADDR : flash_dl_pkg::RC_OK;
                  st_nxt.done = 1'b1;
                end
                default:
                begin
                  st_nxt.gpr0[7:0] = flash_dl_pkg::RC_COMMAND;
                  st_nxt.done = 1'b1;
                end
              endcase
            end
          end
          flash_dl_pkg::OFF_PROG_SEL: st_nxt.prog_sel = hwdata_in[7:0];
          flash_dl_pkg::OFF_KEY: st_nxt.key = hwdata_in[7:0];
          flash_dl_pkg::OFF_DEST: st_nxt.dest = hwdata_in[7:0];
          flash_dl_pkg::OFF_GPR0: st_nxt.gpr0 = hwdata_in;
          flash_dl_pkg::OFF_GPR1: st_nxt.gpr1 = hwdata_in;
          default: st_nxt.hresp = 1'b0;
        endcase
      end
    end

    unique case (st_r.fsm)
      flash_dl_pkg::ST_IDLE:
      begin
        st_nxt.fsm = st_nxt.fsm;
      end
      flash_dl_pkg::ST_COPY:
      begin
        // Image sits just after the result byte at the destination.
        ram.addr = ram_slot(st_r.dest, st_r.idx);
        ram.wdata = prog_byte(st_r.prog_sel, st_r.idx);
        ram.we = 1'b1;
        if (st_r.idx == flash_dl_pkg::PROG_LAST)
        begin
          st_nxt.idx = '0;
          st_nxt.fsm = flash_dl_pkg::ST_VREAD;
        end
        else
        begin
          st_nxt.idx = st_r.idx + 4'h1;
        end
      end
      flash_dl_pkg::ST_VREAD:
      begin
        ram.addr = ram_slot(st_r.dest, st_r.idx);
        st_nxt.fsm = flash_dl_pkg::ST_VCHK;
      end
      flash_dl_pkg::ST_VCHK:
      begin
        if (ram.rdata != prog_byte(st_r.prog_sel, st_r.idx))
        begin
          st_nxt.fail = 1'b1;
        end
        if (st_r.idx == flash_dl_pkg::PROG_LAST)
        begin
          st_nxt.fsm = flash_dl_pkg::ST_RESULT;
        end
        else
        begin
          st_nxt.idx = st_r.idx + 4'h1;
          st_nxt.fsm = flash_dl_pkg::ST_VREAD;
        end
      end
      flash_dl_pkg::ST_RESULT:
      begin
        ram.addr = st_r.dest;
        ram.wdata = make_result(st_r.sel_err, st_r.key_err, st_r.fail);
        ram.we = 1'b1;
        st_nxt.result_byte = make_result(st_r.sel_err, st_r.key_err, st_r.fail);
        st_nxt.gpr0[7:0] = result_code(st_r.sel_err, st_r.key_err, st_r.fail);
        st_nxt.done = 1'b1;
        st_nxt.fsm = flash_dl_pkg::ST_IDLE;
      end
      default:
      begin
        st_nxt.fsm = flash_dl_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      st_r <= '0;
      st_r.fsm <= flash_dl_pkg::ST_IDLE;
      st_r.hready <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout_out = st_r.hready;
  assign hrdata_out = st_r.hrdata;
  assign hresp_out = st_r.hresp;
endmodule // flash_download_result_check
`default_nettype wire

// file: tb/flash_dl_props.sv
// Checker for bus timing and result byte format at the top ports.
`timescale 1ns/1ps
`default_nettype none
module flash_dl_props (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic hreadyout_out,
  input wire logic [31:0] hrdata_out,
  input wire logic hresp_out
);
  typedef struct packed {logic phase; logic write; logic [11:0] addr;} mon_t;
  mon_t mon_r;
  mon_t mon_nxt;
  logic taken;
  logic rd_done;
  assign taken = hsel_in && htrans_in[1] && hready_in;
  assign rd_done = mon_r.phase && !mon_r.write && hreadyout_out;
  always_comb
  begin
    mon_nxt = mon_r;
    if (hreadyout_out)
      mon_nxt.phase = 1'b0;
    if (taken)
      mon_nxt = {1'b1, hwrite_in, haddr_in[11:0]};
  end
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      mon_r <= '0;
    else
      mon_r <= mon_nxt;
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  sequence s_take;
    hsel_in && htrans_in[1] && hready_in;
  endsequence
  sequence s_one_wait;
    !hreadyout_out ##1 hreadyout_out;
  endsequence
  property p_resp_okay;
    hresp_out == 1'b0;
  endproperty
  property p_wait_first;
    s_take |=> !hreadyout_out;
  endproperty
  property p_answer_bound;
    s_take |=> ##[1:80] hreadyout_out;
  endproperty
  property p_reg_answer;
    (taken && !haddr_in[10]) |=> s_one_wait;
  endproperty
  property p_ram_read_wait;
    (taken && haddr_in[10] && !hwrite_in) |=> !hreadyout_out [*2];
  endproperty
  property p_result_zero;
    (rd_done && mon_r.addr == flash_dl_pkg::OFF_RESULT) |-> hrdata_out[31:3] == 29'h0;
  endproperty
  property p_ram_zero;
    (rd_done && mon_r.addr[10]) |-> hrdata_out[31:8] == 24'h0;
  endproperty
  property p_status_zero;
    (rd_done && mon_r.addr == flash_dl_pkg::OFF_CMD) |-> hrdata_out[31:2] == 30'h0;
  endproperty
  property p_result_fail;
    (rd_done && mon_r.addr == flash_dl_pkg::OFF_RESULT && hrdata_out[2:1] != 2'h0) |->
      hrdata_out[0];
  endproperty
  property p_rdata_hold;
    hreadyout_out |=> $stable(hrdata_out);
  endproperty
  a_resp_okay: assert property (p_resp_okay) else $error("response not okay");
  a_wait_first: assert property (p_wait_first) else $error("no wait cycle");
  a_answer_bound: assert property (p_answer_bound) else $error("answer late");
  a_reg_answer: assert property (p_reg_answer) else $error("register answer");
  a_ram_read_wait: assert property (p_ram_read_wait) else $error("ram wait");
  a_result_zero: assert property (p_result_zero) else $error("result high bits");
  a_ram_zero: assert property (p_ram_zero) else $error("ram high bits");
  a_status_zero: assert property (p_status_zero) else $error("status high bits");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  a_result_fail: assert property (p_result_fail) else $error("fail bit clear");
endmodule // flash_dl_props
bind flash_download_result_check flash_dl_props u_props (
  .mclk_in(mclk_in),
  .rst_in(rst_in),
  .hsel_in(hsel_in),
  .haddr_in(haddr_in),
  .htrans_in(htrans_in),
  .hwrite_in(hwrite_in),
  .hsize_in(hsize_in),
  .hwdata_in(hwdata_in),
  .hready_in(hready_in),
  .hreadyout_out(hreadyout_out),
  .hrdata_out(hrdata_out),
  .hresp_out(hresp_out)
);
`default_nettype wire

// file: tb/testbench.sv
// Self-checking testbench for the download result checker.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic hsel_in = 1'b0;
  logic [31:0] haddr_in = 32'h0;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'b0;
  logic [2:0] hsize_in = 3'h2;
  logic [31:0] hwdata_in = 32'h0;
  logic hready_in;
  logic hreadyout_out;
  logic [31:0] hrdata_out;
  logic hresp_out;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  assign hready_in = hreadyout_out;
  always #4 mclk_in = ~mclk_in;
  flash_download_result_check dut (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .hsel_in(hsel_in),
    .haddr_in(haddr_in),
    .htrans_in(htrans_in),
    .hwrite_in(hwrite_in),
    .hsize_in(hsize_in),
    .hwdata_in(hwdata_in),
    .hready_in(hready_in),
    .hreadyout_out(hreadyout_out),
    .hrdata_out(hrdata_out),
    .hresp_out(hresp_out)
  );
  task results;
    $display("Mismatches %0d in %0d checks", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // The whole run needs well under 10000 cycles; the ceiling leaves ample margin.
  always @(posedge mclk_in)
  begin
    cycles = cycles + 1;
    if (cycles == 40000)
    begin
      errors = errors + 1;
      results();
    end
  end
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= {20'h0, a};
    hwrite_in <= wr;
    do
    begin
      @(posedge mclk_in);
      n++;
    end while (hreadyout_out !== 1'b1 && n < 200);
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do
    begin
      @(posedge mclk_in);
      n++;
    end while (hreadyout_out !== 1'b1 && n < 200);
    q = hrdata_out;
    check("bus response", {31'h0, hresp_out}, 32'h0);
    if (n >= 200)
      check("bus ready", 32'h0, 32'h1);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    check(name, q, exp);
  endtask
  function automatic logic [11:0] ram_a(input logic [7:0] i);
    return {2'b01, i, 2'b00};
  endfunction
  task run_cmd(input logic [7:0] cmd);
    logic [31:0] q;
    int k;
    k = 0;
    wr(flash_dl_pkg::OFF_CMD, {24'h0, cmd});
    do
    begin
      xfer(1'b0, flash_dl_pkg::OFF_CMD, 32'h0, q);
      k++;
    end while (q[0] !== 1'b0 && k < 40);
    check("status idle done", q, 32'h2);
  endtask
  task t_regs;
    rd_chk("result reset", flash_dl_pkg::OFF_RESULT, 32'h0);
    wr(flash_dl_pkg::OFF_RESULT, 32'hFFFF_FFFF);
    rd_chk("result read only", flash_dl_pkg::OFF_RESULT, 32'h0);
    rd_chk("unmapped", 12'h01C, 32'h0);
    wr(flash_dl_pkg::OFF_GPR1, 32'h1234_5678);
    rd_chk("gpr1 word", flash_dl_pkg::OFF_GPR1, 32'h1234_5678);
  endtask
  task setup(input logic [7:0] sel, input logic [7:0] key, input logic [7:0] dest);
    wr(flash_dl_pkg::OFF_PROG_SEL, {24'h0, sel});
    wr(flash_dl_pkg::OFF_KEY, {24'h0, key});
    wr(flash_dl_pkg::OFF_DEST, {24'h0, dest});
    wr(flash_dl_pkg::OFF_GPR0, 32'hABCD_EF77);
    run_cmd(flash_dl_pkg::CMD_DOWNLOAD);
  endtask
  task t_download(input logic [7:0] sel, input logic [7:0] dest);
    logic [7:0] seed;
    logic [3:0] i;
    seed = sel[0] ? flash_dl_pkg::PROG_A_SEED : flash_dl_pkg::PROG_B_SEED;
    // A byte just past the image stands for procedure code and must survive the download.
    wr(ram_a(dest + 8'h11), 32'h0000_005A);
    setup(sel, flash_dl_pkg::KEY_VALUE, dest);
    rd_chk("procedure area", ram_a(dest + 8'h11), 32'h0000_005A);
    rd_chk("result ok", flash_dl_pkg::OFF_RESULT, 32'h0);
    rd_chk("code ok", flash_dl_pkg::OFF_GPR0, 32'hABCD_EF00);
    rd_chk("ram result", ram_a(dest), 32'h0);
    for (int n = 0; n < 16; n++)
    begin
      i = n[3:0];
      rd_chk("ram copy", ram_a(dest + {4'h0, i} + 8'h01), {24'h0, seed ^ {i, i}});
    end
  endtask
  task t_fault(input logic [7:0] sel, input logic [7:0] key, input logic [7:0] exp);
    setup(sel, key, 8'h40);
    rd_chk("fault result", flash_dl_pkg::OFF_RESULT, {24'h0, exp});
    rd_chk("fault ram", ram_a(8'h40), {24'h0, exp});
    rd_chk("fault code", flash_dl_pkg::OFF_GPR0, 32'hABCD_EF54);
  endtask
  task t_param(input logic [7:0] cmd, input logic [11:0] preg, input logic [31:0] v,
               input logic [7:0] exp);
    logic [31:0] g;
    g = (preg == flash_dl_pkg::OFF_GPR0) ? {v[31:8], exp} : {24'h0, exp};
    wr(flash_dl_pkg::OFF_GPR0, 32'h0000_00EE);
    wr(preg, v);
    run_cmd(cmd);
    rd_chk("param code", preg, preg == flash_dl_pkg::OFF_GPR0 ? {v[31:8], exp} : v);
    rd_chk("gpr0 code", flash_dl_pkg::OFF_GPR0, g);
  endtask
  initial
  begin
    repeat (8) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_regs();
    t_download(8'h01, 8'h20);
    t_download(8'h02, 8'hF8);
    t_fault(8'h00, 8'hA5, 8'h05);
    t_fault(8'h03, 8'hA5, 8'h05);
    t_fault(8'h04, 8'hA5, 8'h05);
    t_fault(8'h01, 8'h5A, 8'h03);
    t_fault(8'h02, 8'h00, 8'h03);
    t_fault(8'h00, 8'h00, 8'h07);
    t_param(flash_dl_pkg::CMD_FREQ_CHECK, flash_dl_pkg::OFF_GPR0, 32'h1F40, 8'h00);
    t_param(flash_dl_pkg::CMD_FREQ_CHECK, flash_dl_pkg::OFF_GPR0, 32'h1F3F, 8'h27);
    t_param(flash_dl_pkg::CMD_FREQ_CHECK, flash_dl_pkg::OFF_GPR0, 32'h4E20, 8'h00);
    t_param(flash_dl_pkg::CMD_FREQ_CHECK, flash_dl_pkg::OFF_GPR0, 32'h4E21, 8'h27);
    t_param(flash_dl_pkg::CMD_ERASE_CHECK, flash_dl_pkg::OFF_GPR0, 32'h7, 8'h00);
    t_param(flash_dl_pkg::CMD_ERASE_CHECK, flash_dl_pkg::OFF_GPR0, 32'h8, 8'h29);
    t_param(flash_dl_pkg::CMD_ADDR_CHECK, flash_dl_pkg::OFF_GPR1, 32'h100, 8'h00);
    t_param(flash_dl_pkg::CMD_ADDR_CHECK, flash_dl_pkg::OFF_GPR1, 32'h102, 8'h2A);
    t_param(8'h55, flash_dl_pkg::OFF_GPR1, 32'h0, 8'h80);
    rst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    rd_chk("result after reset", flash_dl_pkg::OFF_RESULT, 32'h0);
    rd_chk("ram after reset", ram_a(8'h40), 32'h0);
    results();
  end
endmodule // testbench
`default_nettype wire
